/* rtl/sbp_defs.svh */
/*
 * Offsets, field positions, reset values and scale constants of the
 * shunt, bus, current and power result registers.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

`define SBP_OFS_SHUNT 8'h01
`define SBP_OFS_BUS 8'h02
`define SBP_OFS_POWER 8'h03
`define SBP_OFS_CURRENT 8'h04
`define SBP_BUS_CNT_LSB 3
`define SBP_BUS_FLAG_READY 1
`define SBP_BUS_FLAG_OVF 0
`define SBP_BUS_FULL_WIDE 13'h1f40
`define SBP_BUS_FULL_NARROW 13'h0fa0
`define SBP_SHUNT_FULL_40 17'sh00fa0
`define SBP_SHUNT_FULL_80 17'sh01f40
`define SBP_SHUNT_FULL_160 17'sh03e80
`define SBP_SHUNT_FULL_320 17'sh07d00
`define SBP_CUR_SHIFT 12
`define SBP_POWER_DIV 35'sh1388
`define SBP_CUR_MAX 20'sh07fff
`define SBP_CUR_MIN (-20'sh08000)
`define SBP_POW_MAX 30'sh0000ffff
`define SBP_RST_RESULT 16'h0000
`define SBP_RST_RANGE_WIDE 1'b1
`define SBP_RST_GAIN 2'h3
`define SBP_MODE_PWRDN 3'h0
`define SBP_MODE_ADC_OFF 3'h4

`endif

/* rtl/sbp_pkg.sv */
/*
 * Types of the result register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sbp_pkg;
    typedef enum logic [1:0] {
        SBP_IDLE,
        SBP_CURRENT,
        SBP_POWER
    } sbp_math_e;
    typedef logic [15:0] sbp_word_t;
endpackage

/* rtl/sbp_result_regs.sv */
/*
 * Result registers of a shunt, bus, current and power monitor: shunt
 * clamping, bus word with ready and overflow flags, current and power math.
 * Assumes measurements arrive as one-cycle strobes with raw signed or
 * unsigned counts, and that the serial engine gives read strobes with an
 * address and a mode-write strobe with the new mode.
 */
`include "sbp_defs.svh"

module sbp_result_regs (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic BUS_RANGE_SELECT,
    input wire logic [1:0] SHUNT_GAIN_SELECT,
    input wire logic [15:0] CALIBRATION,
    input wire logic SHUNT_VALID,
    input wire logic signed [16:0] SHUNT_RAW,
    input wire logic BUS_VALID,
    input wire logic [12:0] BUS_RAW,
    input wire logic CYCLE_DONE,
    input wire logic MODE_WRITE,
    input wire logic [2:0] MODE_VALUE,
    input wire logic RD_STROBE,
    input wire logic [7:0] RD_ADDR,
    output logic [15:0] RD_DATA,
    output logic CONVERSION_READY,
    output logic MATH_BUSY
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic signed [16:0] shunt_full;
    logic signed [16:0] shunt_clamped;
    sbp_pkg::sbp_word_t shunt_q;
    sbp_pkg::sbp_word_t bus_word;
    logic [12:0] bus_cnt_q;
    logic bus_narrow_q;
    sbp_pkg::sbp_word_t current_q;
    sbp_pkg::sbp_word_t power_q;
    logic ready_q;
    logic ovf_q;
    logic pend_q;
    sbp_pkg::sbp_math_e math_q;
    logic signed [31:0] cur_prod;
    logic signed [19:0] cur_div;
    logic signed [29:0] pow_prod;
    logic signed [29:0] pow_div;
    logic cur_ovf;
    logic pow_ovf;
    logic clear_ready;
    logic mode_clear;
    logic power_read;
    sbp_pkg::sbp_word_t rd_data_d;

    // Reset leaves through two flops
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Full scale per gain code
    always_comb begin
        unique case (SHUNT_GAIN_SELECT)
            2'h0: shunt_full = `SBP_SHUNT_FULL_40;
            2'h1: shunt_full = `SBP_SHUNT_FULL_80;
            2'h2: shunt_full = `SBP_SHUNT_FULL_160;
            2'h3: shunt_full = `SBP_SHUNT_FULL_320;
        endcase
        if (SHUNT_RAW > shunt_full)
            shunt_clamped = shunt_full;
        else if (SHUNT_RAW < -shunt_full)
            shunt_clamped = -shunt_full;
        else
            shunt_clamped = SHUNT_RAW;
    end

    // Only clamped counts reach the register
    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q)
            shunt_q <= `SBP_RST_RESULT;
        else if (CLK_EN && SHUNT_VALID)
            shunt_q <= shunt_clamped[15:0];
    end

    // Latest bus measurement, range applied
    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            bus_cnt_q <= 13'h0000;
            bus_narrow_q <= ~`SBP_RST_RANGE_WIDE;
        end else if (CLK_EN && BUS_VALID) begin
            bus_narrow_q <= ~BUS_RANGE_SELECT;
            if (BUS_RANGE_SELECT)
                bus_cnt_q <= (BUS_RAW > `SBP_BUS_FULL_WIDE) ?
                    `SBP_BUS_FULL_WIDE : BUS_RAW;
            else
                bus_cnt_q <= (BUS_RAW > `SBP_BUS_FULL_NARROW) ?
                    `SBP_BUS_FULL_NARROW : BUS_RAW;
        end
    end

    // Bit 2 unused, always reads zero
    always_comb begin
        bus_word = {bus_cnt_q, 3'h0};
        if (bus_narrow_q)
            bus_word[15] = 1'b0;
        bus_word[`SBP_BUS_FLAG_READY] = ready_q;
        bus_word[`SBP_BUS_FLAG_OVF] = ovf_q;
    end

    // Current math; calibration bit 0 takes no part
    always_comb begin
        cur_prod = $signed(shunt_q) * $signed({1'b0, CALIBRATION[15:1], 1'b0});
        cur_div = 20'(cur_prod >>> `SBP_CUR_SHIFT);
        cur_ovf = (cur_div > `SBP_CUR_MAX) ||
            (cur_div < `SBP_CUR_MIN);
    end

    // Power math uses the current stored one step earlier
    always_comb begin
        pow_prod = $signed(current_q) * $signed({1'b0, bus_cnt_q});
        pow_div = 30'(35'(pow_prod) / `SBP_POWER_DIV);
        pow_ovf = (pow_div > `SBP_POW_MAX) || (pow_div < 30'sh0);
    end

    // One step each for current, then power
    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            math_q <= sbp_pkg::SBP_IDLE;
            pend_q <= 1'b0;
            current_q <= `SBP_RST_RESULT;
            power_q <= `SBP_RST_RESULT;
            ovf_q <= 1'b0;
        end else if (CLK_EN) begin
            unique case (math_q)
                sbp_pkg::SBP_IDLE: begin
                    // Cycle start ignored while a sequence runs
                    if (CYCLE_DONE)
                        math_q <= sbp_pkg::SBP_CURRENT;
                end
                sbp_pkg::SBP_CURRENT: begin
                    current_q <= cur_div[15:0];
                    ovf_q <= cur_ovf;
                    math_q <= sbp_pkg::SBP_POWER;
                end
                sbp_pkg::SBP_POWER: begin
                    power_q <= pow_div[15:0];
                    ovf_q <= ovf_q | pow_ovf;
                    math_q <= sbp_pkg::SBP_IDLE;
                end
                default: math_q <= sbp_pkg::SBP_IDLE;
            endcase
            // Ready follows the power step
            pend_q <= (math_q == sbp_pkg::SBP_POWER);
        end
    end

    // Off modes leave the ready flag alone
    assign mode_clear = MODE_WRITE && MODE_VALUE != `SBP_MODE_PWRDN &&
        MODE_VALUE != `SBP_MODE_ADC_OFF;
    assign power_read = RD_STROBE && RD_ADDR == `SBP_OFS_POWER;
    assign clear_ready = mode_clear || power_read;

    // Set wins over clear
    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q)
            ready_q <= 1'b0;
        else if (CLK_EN) begin
            if (pend_q)
                ready_q <= 1'b1;
            else if (clear_ready)
                ready_q <= 1'b0;
        end
    end

    // Unmapped offsets read as zero
    always_comb begin
        unique case (RD_ADDR)
            `SBP_OFS_SHUNT: rd_data_d = shunt_q;
            `SBP_OFS_BUS: rd_data_d = bus_word;
            `SBP_OFS_POWER: rd_data_d = power_q;
            `SBP_OFS_CURRENT: rd_data_d = current_q;
            default: rd_data_d = `SBP_RST_RESULT;
        endcase
    end

    // Read path freezes while CLK_EN is low
    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            RD_DATA <= `SBP_RST_RESULT;
            CONVERSION_READY <= 1'b0;
            MATH_BUSY <= 1'b0;
        end else if (CLK_EN) begin
            // Flag copy lags the flag by one cycle
            CONVERSION_READY <= ready_q;
            MATH_BUSY <= (math_q != sbp_pkg::SBP_IDLE);
            if (RD_STROBE)
                RD_DATA <= rd_data_d;
        end
    end
endmodule

/* sim/sbp_result_regs_chk.sv */
/* Port checker of the result registers.
   Bound to sbp_result_regs; assumes CLK_EN drops only while idle. */
module sbp_result_regs_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CYCLE_DONE,
    input wire logic MATH_BUSY,
    input wire logic MODE_WRITE,
    input wire logic [2:0] MODE_VALUE,
    input wire logic RD_STROBE,
    input wire logic [7:0] RD_ADDR,
    input wire logic [15:0] RD_DATA,
    input wire logic CONVERSION_READY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    sequence s_math;
        CYCLE_DONE && !MATH_BUSY;
    endsequence
    sequence s_quiet;
        (!RD_STROBE && !MODE_WRITE) [*3];
    endsequence
    a_ready_on_time: assert property (s_math ##1 s_quiet |=> ##1
        CONVERSION_READY) else $error("ready late");
    a_busy_start: assert property (s_math |=> ##1 MATH_BUSY)
        else $error("math not started");
    a_ready_cause: assert property ($rose(CONVERSION_READY) |->
        $past(CYCLE_DONE, 5)) else $error("ready without math");
    a_power_rd_clr: assert property (RD_STROBE && RD_ADDR == 8'h03 &&
        !$past(CYCLE_DONE, 3) |-> ##2 !CONVERSION_READY)
        else $error("power read kept ready");
    a_mode_clr: assert property (MODE_WRITE && MODE_VALUE != 3'h0 &&
        MODE_VALUE != 3'h4 && !$past(CYCLE_DONE, 3) |-> ##2
        !CONVERSION_READY) else $error("mode write kept ready");
    a_bit2_zero: assert property (RD_STROBE && RD_ADDR == 8'h02 |=>
        !RD_DATA[2]) else $error("bus bit 2 set");
    a_unmapped_zero: assert property (RD_STROBE && RD_ADDR > 8'h04 |=>
        RD_DATA == 16'h0000) else $error("unmapped read");
    a_data_hold: assert property (!RD_STROBE |=> $stable(RD_DATA))
        else $error("read data moved");
    a_shunt_clamp: assert property (RD_STROBE && RD_ADDR == 8'h01 |=>
        $signed(RD_DATA) <= 32000 && $signed(RD_DATA) >= -32000)
        else $error("shunt out of range");
endmodule
bind sbp_result_regs sbp_result_regs_chk u_chk (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .CYCLE_DONE(CYCLE_DONE),
    .MATH_BUSY(MATH_BUSY),
    .MODE_WRITE(MODE_WRITE),
    .MODE_VALUE(MODE_VALUE),
    .RD_STROBE(RD_STROBE),
    .RD_ADDR(RD_ADDR),
    .RD_DATA(RD_DATA),
    .CONVERSION_READY(CONVERSION_READY)
);

/* sim/sbp_host_model.sv */
/* Serial host side: register reads and mode writes.
   Assumes RD_DATA is valid one cycle after the strobe. */
module sbp_host_model (
    input wire logic CLK_SYS,
    input wire logic [15:0] RD_DATA,
    output logic RD_STROBE,
    output logic [7:0] RD_ADDR,
    output logic MODE_WRITE,
    output logic [2:0] MODE_VALUE
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        RD_STROBE = 1'b0;
        RD_ADDR = 8'h5a;
        MODE_WRITE = 1'b0;
        MODE_VALUE = 3'h5;
    end
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK_SYS);
        #1 RD_STROBE = 1'b1;
        RD_ADDR = a;
        @(posedge CLK_SYS);
        #1 RD_STROBE = 1'b0;
        RD_ADDR = ~a;
        d = RD_DATA;
    endtask
    task automatic wr_mode(input logic [2:0] m);
        @(posedge CLK_SYS);
        #1 MODE_WRITE = 1'b1;
        MODE_VALUE = m;
        @(posedge CLK_SYS);
        #1 MODE_WRITE = 1'b0;
        MODE_VALUE = ~m;
    endtask
endmodule

/* sim/testbench.sv */
/* Random and corner bench of the result registers.
   Assumes host model and checker are compiled first. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'b0;
    logic RST_N = 1'b0;
    logic CLK_EN = 1'b1;
    logic BUS_RANGE_SELECT = 1'b1;
    logic [1:0] SHUNT_GAIN_SELECT = 2'h3;
    logic [15:0] CALIBRATION = 16'h0000;
    logic SHUNT_VALID = 1'b0;
    logic signed [16:0] SHUNT_RAW = 17'sh00000;
    logic BUS_VALID = 1'b0;
    logic [12:0] BUS_RAW = 13'h0000;
    logic CYCLE_DONE = 1'b0;
    logic MODE_WRITE, RD_STROBE, CONVERSION_READY, MATH_BUSY, co, ov;
    logic [2:0] MODE_VALUE;
    logic [7:0] RD_ADDR;
    logic [15:0] RD_DATA, d;
    int err_total = 0;
    int n_compared = 0;
    longint sv, bv, cv, pv;
    sbp_result_regs dut (
        .CLK_SYS(CLK_SYS),
        .RST_N(RST_N),
        .CLK_EN(CLK_EN),
        .BUS_RANGE_SELECT(BUS_RANGE_SELECT),
        .SHUNT_GAIN_SELECT(SHUNT_GAIN_SELECT),
        .CALIBRATION(CALIBRATION),
        .SHUNT_VALID(SHUNT_VALID),
        .SHUNT_RAW(SHUNT_RAW),
        .BUS_VALID(BUS_VALID),
        .BUS_RAW(BUS_RAW),
        .CYCLE_DONE(CYCLE_DONE),
        .MODE_WRITE(MODE_WRITE),
        .MODE_VALUE(MODE_VALUE),
        .RD_STROBE(RD_STROBE),
        .RD_ADDR(RD_ADDR),
        .RD_DATA(RD_DATA),
        .CONVERSION_READY(CONVERSION_READY),
        .MATH_BUSY(MATH_BUSY)
    );
    sbp_host_model u_host (
        .CLK_SYS(CLK_SYS),
        .RD_DATA(RD_DATA),
        .RD_STROBE(RD_STROBE),
        .RD_ADDR(RD_ADDR),
        .MODE_WRITE(MODE_WRITE),
        .MODE_VALUE(MODE_VALUE)
    );
    always #2 CLK_SYS = ~CLK_SYS;
    function automatic longint clampv(longint v, longint l);
        return v > l ? l : (v < -l ? -l : v);
    endfunction
    function automatic logic [15:0] busw(logic r);
        return {bv[12:0], 1'b0, r, ov};
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t read %h want %h", $time, s, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        u_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        int k;
        k = $urandom(40777);
        repeat (2) @(posedge CLK_SYS);
        #1 RST_N = 1'b1;
        repeat (4) @(posedge CLK_SYS);
        rdc(8'h03, 16'h0000);
        rdc(8'h04, 16'h0000);
        rdc(8'h07, 16'h0000);
        for (int i = 0; i < 48; i++) begin
            BUS_RANGE_SELECT = 1'($urandom);
            SHUNT_GAIN_SELECT = i < 8 ? 2'(i / 2) : 2'($urandom);
            CALIBRATION = 16'($urandom);
            SHUNT_RAW = i < 8 ? (i % 2 ? -17'sd32002 : 17'sd32002) :
                17'(int'($urandom_range(80000)) - 40000);
            BUS_RAW = 13'($urandom);
            @(posedge CLK_SYS);
            #1 SHUNT_VALID = 1'b1;
            BUS_VALID = 1'b1;
            @(posedge CLK_SYS);
            #1 SHUNT_VALID = 1'b0;
            BUS_VALID = 1'b0;
            CYCLE_DONE = 1'b1;
            @(posedge CLK_SYS);
            #1 CYCLE_DONE = 1'b0;
            for (k = 0; k < 20 && CONVERSION_READY !== 1'b1; k++) begin
                @(posedge CLK_SYS);
                #1;
            end
            if (k == 20) begin
                err_total++;
                break;
            end
            sv = clampv(SHUNT_RAW, 64'sd4000 <<< SHUNT_GAIN_SELECT);
            bv = BUS_RANGE_SELECT ? 8000 : 4000;
            bv = BUS_RAW < bv ? BUS_RAW : bv;
            cv = sv * longint'(CALIBRATION & 16'hfffe) >>> 12;
            co = cv > 32767 || cv < -32768;
            pv = longint'($signed(16'(cv))) * bv / 5000;
            ov = co || pv < 0 || pv > 65535;
            rdc(8'h01, 16'(sv));
            rdc(8'h02, busw(1'b1));
            rdc(8'h04, 16'(cv));
            u_host.wr_mode(3'(i));
            rdc(8'h02, busw(i % 8 == 0 || i % 8 == 4));
            rdc(8'h03, 16'(pv));
            rdc(8'h02, busw(1'b0));
        end
        CLK_EN = 1'b0;
        rdc(8'h04, busw(1'b0));
        CLK_EN = 1'b1;
        RST_N = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1 RST_N = 1'b1;
        repeat (4) @(posedge CLK_SYS);
        rdc(8'h03, 16'h0000);
        rdc(8'h04, 16'h0000);
        rdc(8'h02, 16'h0000);
        wrap_up();
    end
endmodule
